// [src/mon_pkg.sv]
package mon_pkg;

  // ==========================================================
  // Register addresses
  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_SYNC = 13'h0100;
  localparam logic [12:0] ADDR_FD_CTRL = 13'h0104;
  localparam logic [12:0] ADDR_COARSE = 13'h0105;
  localparam logic [12:0] ADDR_FHI_LO = 13'h0106;
  localparam logic [12:0] ADDR_FHI_HI = 13'h0107;
  localparam logic [12:0] ADDR_FLO_LO = 13'h0108;
  localparam logic [12:0] ADDR_FLO_HI = 13'h0109;
  localparam logic [12:0] ADDR_DWELL_LO = 13'h010A;
  localparam logic [12:0] ADDR_DWELL_HI = 13'h010B;
  localparam logic [12:0] ADDR_DC_CTRL = 13'h010C;
  localparam logic [12:0] ADDR_RESULT_SERIAL_PORT = 13'h0111;
  localparam logic [12:0] ADDR_MON_CTRL = 13'h0112;
  localparam logic [12:0] ADDR_PER_B0 = 13'h0113;
  localparam logic [12:0] ADDR_PER_B1 = 13'h0114;
  localparam logic [12:0] ADDR_PER_B2 = 13'h0115;
  localparam logic [12:0] ADDR_RES_A0 = 13'h0116;
  localparam logic [12:0] ADDR_RES_A1 = 13'h0117;
  localparam logic [12:0] ADDR_RES_A2 = 13'h0118;
  localparam logic [12:0] ADDR_RES_B0 = 13'h0119;
  localparam logic [12:0] ADDR_RES_B1 = 13'h011A;
  localparam logic [12:0] ADDR_RES_B2 = 13'h011B;

  // ==========================================================
  // Implemented bit masks and reset values
  localparam logic [7:0] MASK_SYNC = 8'h87;
  localparam logic [7:0] MASK_FD = 8'h0F;
  localparam logic [7:0] MASK_COARSE = 8'h07;
  localparam logic [7:0] MASK_HI5 = 8'h1F;
  localparam logic [7:0] MASK_DC = 8'h7F;
  localparam logic [7:0] MASK_RESULT_SERIAL_PORT = 8'h7F;
  localparam logic [7:0] MASK_MON = 8'h8F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RESULT_SERIAL_PORT = 8'h04;
  localparam logic [23:0] RST_PERIOD = 24'h000080;
  localparam logic [23:0] PERIOD_MIN = 24'h000080;

  // ==========================================================
  // Field positions
  localparam int SYNC_MON_BIT = 7;
  localparam int SYNC_ONCE_BIT = 2;
  localparam int SYNC_DIV_BIT = 1;
  localparam int SYNC_MASTER_BIT = 0;
  localparam int FD_EN_BIT = 0;
  localparam int DC_FREEZE_BIT = 6;
  localparam int SP_RMS_BIT = 6;
  localparam int SP_PEAK_BIT = 5;
  localparam int SP_THR_BIT = 4;
  localparam int SP_SLEEP_BIT = 1;
  localparam int SP_EN_BIT = 0;
  localparam int MC_CPLX_BIT = 7;
  localparam int MC_MS_BIT = 3;
  localparam int MC_EN_BIT = 0;

  // ==========================================================
  // Widths, divider codes and levels
  localparam int MAG_W = 13;
  localparam int RES_W = 20;
  localparam logic [4:0] BITS_RMS = 5'h14;
  localparam logic [4:0] BITS_SHORT = 5'h0D;
  localparam logic [1:0] DIV_CODE_4 = 2'h2;
  localparam logic [1:0] DIV_CODE_8 = 2'h3;
  localparam logic [3:0] DIV_2 = 4'h2;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_8 = 4'h8;
  localparam logic [12:0] COARSE_BASE = 13'h0020;
  localparam logic [1:0] MODE_CODE_PEAK = 2'h1;

  typedef enum logic [1:0] {MON_RMS, MON_PEAK, MON_THRESH} mon_mode_t;
  typedef enum logic {SP_IDLE, SP_SHIFT} sp_state_t;

endpackage : mon_pkg

// [src/mon_if.sv]
`timescale 1ns/100ps
// Threshold settings out, per-channel flags back
interface thr_if;
  logic [2:0] coarse_code;
  logic [12:0] high_level;
  logic [12:0] low_level;
  logic [15:0] dwell;
  logic [12:0] mag;
  logic coarse_hit;
  logic fine_high_flag;
  logic fine_low_flag;
  logic gain_raise;
  modport ctrl (output coarse_code, high_level, low_level, dwell, mag,
                input coarse_hit, fine_high_flag, fine_low_flag, gain_raise);
  modport det (input coarse_code, high_level, low_level, dwell, mag,
               output coarse_hit, fine_high_flag, fine_low_flag, gain_raise);
endinterface : thr_if

// Result words to the serial result port
interface sp_if;
  logic start;
  logic en;
  logic sleep;
  logic [1:0] div_code;
  logic [4:0] nbits;
  logic [19:0] word_a;
  logic [19:0] word_b;
  logic busy;
  logic bit_clk;
  logic bit_data;
  logic frame;
  modport ctrl (output start, en, sleep, div_code, nbits, word_a, word_b,
                input busy, bit_clk, bit_data, frame);
  modport port (input start, en, sleep, div_code, nbits, word_a, word_b,
                output busy, bit_clk, bit_data, frame);
endinterface : sp_if

// [src/level_detect.sv]
`timescale 1ns/100ps
module level_detect
  import mon_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Settings and flags
  thr_if.det thr
);

  logic [15:0] below_cnt_q;
  logic [15:0] below_cnt_d;
  logic below;

  // Consecutive cycles below the fine low level, saturating
  assign below = thr.mag < thr.low_level;
  always_comb begin
    below_cnt_d = 16'h0000;
    if (below) begin
      below_cnt_d = (below_cnt_q == 16'hFFFF) ? below_cnt_q : below_cnt_q + 16'h0001;
    end
  end

  // Level comparisons and dwell qualified gain request
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      below_cnt_q <= 16'h0000;
      thr.coarse_hit <= 1'b0;
      thr.fine_high_flag <= 1'b0;
      thr.fine_low_flag <= 1'b0;
      thr.gain_raise <= 1'b0;
    end else begin
      below_cnt_q <= below_cnt_d;
      thr.coarse_hit <= thr.mag >= (COARSE_BASE << thr.coarse_code);
      thr.fine_high_flag <= thr.mag > thr.high_level;
      thr.fine_low_flag <= below;
      thr.gain_raise <= below && (below_cnt_d >= thr.dwell);
    end
  end

endmodule : level_detect

// [src/result_port.sv]
`timescale 1ns/100ps
module result_port
  import mon_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Result words and serial pins
  sp_if.port sp
);

  sp_state_t state_q;
  logic [3:0] div_cnt_q;
  logic [3:0] div_n;
  logic [39:0] shift_q;
  logic [5:0] left_q;
  logic wrap;

  // Bit clock ratio from the divide field
  always_comb begin
    case (sp.div_code)
      DIV_CODE_4: div_n = DIV_4;
      DIV_CODE_8: div_n = DIV_8;
      default: div_n = DIV_2;
    endcase
  end
  assign wrap = div_cnt_q >= div_n - 4'h1;

  // Free running divider, one bit per wrap
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= wrap ? 4'h0 : div_cnt_q + 4'h1;
    end
  end

  // Shifter: channel A then channel B, MSB first
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= SP_IDLE;
      shift_q <= 40'h0000000000;
      left_q <= 6'h00;
      sp.bit_data <= 1'b0;
      sp.frame <= 1'b0;
    end else begin
      case (state_q)
        SP_IDLE: begin
          if (sp.start && sp.en) begin
            shift_q <= {sp.word_a << (BITS_RMS - sp.nbits), 20'h00000}
              | ({20'h00000, sp.word_b << (BITS_RMS - sp.nbits)} << (BITS_RMS - sp.nbits));
            left_q <= {sp.nbits, 1'b0};
            state_q <= SP_SHIFT;
          end
        end
        SP_SHIFT: begin
          if (wrap) begin
            if (left_q == 6'h00) begin
              state_q <= SP_IDLE;
              sp.frame <= 1'b0;
              sp.bit_data <= 1'b0;
            end else begin
              sp.bit_data <= shift_q[39];
              sp.frame <= 1'b1;
              shift_q <= {shift_q[38:0], 1'b0};
              left_q <= left_q - 6'h01;
            end
          end
        end
        default: state_q <= SP_IDLE;
      endcase
    end
  end

  // Bit clock, held low while idle in sleep
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sp.bit_clk <= 1'b0;
    end else begin
      sp.bit_clk <= (state_q == SP_SHIFT || !sp.sleep) && (div_cnt_q < (div_n >> 1));
    end
  end
  assign sp.busy = state_q == SP_SHIFT;

endmodule : result_port

// [src/adc_monitor_sync_detect_regs.sv]
`timescale 1ns/100ps
module adc_monitor_sync_detect_regs
  import mon_pkg::*;
#(
  parameter int REG_ADDR_W = ADDR_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Serial control port register access
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // External sync
  input wire logic sync_i,
  output logic monitor_sync_o,
  output logic divider_sync_o,
  // Sample magnitudes and channel state
  input wire logic [12:0] mag_a_i,
  input wire logic [12:0] mag_b_i,
  input wire logic interleave_i,
  input wire logic chan_a_off_i,
  input wire logic chan_b_off_i,
  // Fast flag pins and level flags
  output logic [3:0] fast_flag_o,
  output logic fast_flag_oe_o,
  output logic [1:0] fine_high_flag_o,
  output logic [1:0] fine_low_flag_o,
  output logic [1:0] gain_raise_o,
  // Monitor datapath
  input wire logic [13:0] dc_calc_a_i,
  input wire logic [13:0] dc_calc_b_i,
  output logic [13:0] dc_applied_a_o,
  output logic [13:0] dc_applied_b_o,
  output logic [7:0] dc_ctrl_o,
  input wire logic [19:0] result_a_i,
  input wire logic [19:0] result_b_i,
  output logic monitor_en_o,
  output logic [1:0] monitor_mode_o,
  output logic monitor_ms_o,
  output logic monitor_complex_o,
  output logic period_end_o,
  // Result serial port
  output logic result_serial_port_clk_o,
  output logic result_serial_port_data_o,
  output logic result_serial_port_frame_o
);

  // ==========================================================
  // Elaboration checks
  if (REG_ADDR_W < ADDR_W) begin : g_addr_check
    $error("register address width too small");
  end

  // ==========================================================
  // Register state
  logic [7:0] sync_ctrl_q;
  logic [7:0] fd_ctrl_q;
  logic [7:0] coarse_q;
  logic [12:0] fine_high_q;
  logic [12:0] fine_low_q;
  logic [15:0] dwell_q;
  logic [7:0] dc_ctrl_q;
  logic [7:0] result_serial_port_q;
  logic [7:0] mon_ctrl_q;
  logic [23:0] period_q;
  logic [19:0] res_a_q;
  logic [19:0] res_b_q;
  logic [12:0] addr;
  logic wr_sync;
  logic sync_master;
  logic div_pass;
  logic mon_pass;

  assign addr = reg_addr_i[ADDR_W-1:0];
  assign wr_sync = reg_wr_i && (addr == ADDR_SYNC);
  assign sync_master = sync_ctrl_q[SYNC_MASTER_BIT];
  assign div_pass = sync_i && sync_master && sync_ctrl_q[SYNC_DIV_BIT];
  assign mon_pass = sync_i && sync_master && sync_ctrl_q[SYNC_MON_BIT];

  // Sync control, with divider enable self-clearing in next-sync-only use
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_ctrl_q <= RST_ZERO;
    end else if (wr_sync) begin
      sync_ctrl_q <= reg_wdata_i & MASK_SYNC;
    end else if (div_pass && sync_ctrl_q[SYNC_ONCE_BIT]) begin
      sync_ctrl_q[SYNC_DIV_BIT] <= 1'b0;
    end
  end

  // Sync outputs
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      monitor_sync_o <= 1'b0;
      divider_sync_o <= 1'b0;
    end else begin
      monitor_sync_o <= mon_pass;
      divider_sync_o <= div_pass;
    end
  end

  // Read-write configuration registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fd_ctrl_q <= RST_ZERO;
      coarse_q <= RST_ZERO;
      fine_high_q <= 13'h0000;
      fine_low_q <= 13'h0000;
      dwell_q <= 16'h0000;
      dc_ctrl_q <= RST_ZERO;
      result_serial_port_q <= RST_RESULT_SERIAL_PORT;
      mon_ctrl_q <= RST_ZERO;
      period_q <= RST_PERIOD;
    end else if (reg_wr_i) begin
      case (addr)
        ADDR_FD_CTRL: fd_ctrl_q <= reg_wdata_i & MASK_FD;
        ADDR_COARSE: coarse_q <= reg_wdata_i & MASK_COARSE;
        ADDR_FHI_LO: fine_high_q[7:0] <= reg_wdata_i;
        ADDR_FHI_HI: fine_high_q[12:8] <= reg_wdata_i[4:0];
        ADDR_FLO_LO: fine_low_q[7:0] <= reg_wdata_i;
        ADDR_FLO_HI: fine_low_q[12:8] <= reg_wdata_i[4:0];
        ADDR_DWELL_LO: dwell_q[7:0] <= reg_wdata_i;
        ADDR_DWELL_HI: dwell_q[15:8] <= reg_wdata_i;
        ADDR_DC_CTRL: dc_ctrl_q <= reg_wdata_i & MASK_DC;
        ADDR_RESULT_SERIAL_PORT: result_serial_port_q <= reg_wdata_i & MASK_RESULT_SERIAL_PORT;
        ADDR_MON_CTRL: mon_ctrl_q <= reg_wdata_i & MASK_MON;
        ADDR_PER_B0: period_q[7:0] <= reg_wdata_i;
        ADDR_PER_B1: period_q[15:8] <= reg_wdata_i;
        ADDR_PER_B2: period_q[23:16] <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Read port, unmapped and reserved bits return zero
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (addr)
          ADDR_SYNC: reg_rdata_o <= sync_ctrl_q;
          ADDR_FD_CTRL: reg_rdata_o <= fd_ctrl_q;
          ADDR_COARSE: reg_rdata_o <= coarse_q;
          ADDR_FHI_LO: reg_rdata_o <= fine_high_q[7:0];
          ADDR_FHI_HI: reg_rdata_o <= {3'h0, fine_high_q[12:8]};
          ADDR_FLO_LO: reg_rdata_o <= fine_low_q[7:0];
          ADDR_FLO_HI: reg_rdata_o <= {3'h0, fine_low_q[12:8]};
          ADDR_DWELL_LO: reg_rdata_o <= dwell_q[7:0];
          ADDR_DWELL_HI: reg_rdata_o <= dwell_q[15:8];
          ADDR_DC_CTRL: reg_rdata_o <= dc_ctrl_q;
          ADDR_RESULT_SERIAL_PORT: reg_rdata_o <= result_serial_port_q;
          ADDR_MON_CTRL: reg_rdata_o <= mon_ctrl_q;
          ADDR_PER_B0: reg_rdata_o <= period_q[7:0];
          ADDR_PER_B1: reg_rdata_o <= period_q[15:8];
          ADDR_PER_B2: reg_rdata_o <= period_q[23:16];
          ADDR_RES_A0: reg_rdata_o <= res_a_q[7:0];
          ADDR_RES_A1: reg_rdata_o <= res_a_q[15:8];
          ADDR_RES_A2: reg_rdata_o <= {4'h0, res_a_q[19:16]};
          ADDR_RES_B0: reg_rdata_o <= res_b_q[7:0];
          ADDR_RES_B1: reg_rdata_o <= res_b_q[15:8];
          ADDR_RES_B2: reg_rdata_o <= {4'h0, res_b_q[19:16]};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Level detectors, one per channel
  logic [1:0][12:0] mag;
  logic [1:0][1:0] pick;
  logic [1:0] coarse_hit;
  logic [1:0] fine_high;
  logic [1:0] fine_low;
  logic [1:0] gain_raise;

  assign mag[0] = mag_a_i;
  assign mag[1] = mag_b_i;

  for (genvar g = 0; g < 2; g++) begin : g_chan
    thr_if tif();
    assign tif.coarse_code = coarse_q[2:0];
    assign tif.high_level = fine_high_q;
    assign tif.low_level = fine_low_q;
    assign tif.dwell = dwell_q;
    assign tif.mag = mag[g];
    assign coarse_hit[g] = tif.coarse_hit;
    assign fine_high[g] = tif.fine_high_flag;
    assign fine_low[g] = tif.fine_low_flag;
    assign gain_raise[g] = tif.gain_raise;

    level_detect u_detect (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .thr (tif.det)
    );

    // Pin content for this channel from the mode field
    always_comb begin
      case (fd_ctrl_q[3:1])
        3'h0: pick[g] = {coarse_hit[g], fine_high[g]};
        3'h1: pick[g] = {fine_high[g], fine_low[g]};
        3'h2: pick[g] = {fine_high[g], gain_raise[g]};
        3'h3: pick[g] = {coarse_hit[g], gain_raise[g]};
        3'h4: pick[g] = {gain_raise[g], fine_low[g]};
        default: pick[g] = 2'h0;
      endcase
    end
  end

  // Level flag outputs
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fine_high_flag_o <= 2'h0;
      fine_low_flag_o <= 2'h0;
      gain_raise_o <= 2'h0;
    end else begin
      fine_high_flag_o <= fine_high;
      fine_low_flag_o <= fine_low;
      gain_raise_o <= gain_raise;
    end
  end

  // ==========================================================
  // Fast flag pins, interleaved slot alternates channels
  logic slot_q;
  logic both_off;
  logic [1:0] act;

  assign both_off = chan_a_off_i && chan_b_off_i;
  always_comb begin
    if (chan_a_off_i) begin
      act = pick[1];
    end else if (chan_b_off_i) begin
      act = pick[0];
    end else begin
      act = slot_q ? pick[1] : pick[0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_q <= 1'b0;
      fast_flag_o <= 4'h0;
      fast_flag_oe_o <= 1'b0;
    end else begin
      slot_q <= ~slot_q;
      if (!fd_ctrl_q[FD_EN_BIT]) begin
        fast_flag_o <= 4'h0;
        fast_flag_oe_o <= 1'b0;
      end else if (interleave_i) begin
        fast_flag_o <= {act, act};
        fast_flag_oe_o <= !both_off;
      end else begin
        fast_flag_o <= {pick[1], pick[0]};
        fast_flag_oe_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Dc estimate hold while frozen
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dc_applied_a_o <= 14'h0000;
      dc_applied_b_o <= 14'h0000;
      dc_ctrl_o <= 8'h00;
    end else begin
      dc_ctrl_o <= dc_ctrl_q;
      if (!dc_ctrl_q[DC_FREEZE_BIT]) begin
        dc_applied_a_o <= dc_calc_a_i;
        dc_applied_b_o <= dc_calc_b_i;
      end
    end
  end

  // ==========================================================
  // Monitor mode decode and period counter
  mon_mode_t mode;
  logic [23:0] period_eff;
  logic [23:0] per_cnt_q;
  logic per_wrap;
  logic mode_out_en;

  always_comb begin
    if (mon_ctrl_q[2:1] == 2'h0) begin
      mode = MON_RMS;
    end else if (mon_ctrl_q[2:1] == MODE_CODE_PEAK) begin
      mode = MON_PEAK;
    end else begin
      mode = MON_THRESH;
    end
  end
  assign period_eff = (period_q < PERIOD_MIN) ? PERIOD_MIN : period_q;
  assign per_wrap = mon_ctrl_q[MC_EN_BIT] && (per_cnt_q >= period_eff - 24'h000001);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      per_cnt_q <= 24'h000000;
      period_end_o <= 1'b0;
      res_a_q <= 20'h00000;
      res_b_q <= 20'h00000;
    end else begin
      period_end_o <= per_wrap;
      if (!mon_ctrl_q[MC_EN_BIT] || mon_pass || per_wrap) begin
        per_cnt_q <= 24'h000000;
      end else begin
        per_cnt_q <= per_cnt_q + 24'h000001;
      end
      if (per_wrap) begin
        res_a_q <= result_a_i;
        res_b_q <= result_b_i;
      end
    end
  end

  // Monitor control outputs
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      monitor_en_o <= 1'b0;
      monitor_mode_o <= 2'h0;
      monitor_ms_o <= 1'b0;
      monitor_complex_o <= 1'b0;
    end else begin
      monitor_en_o <= mon_ctrl_q[MC_EN_BIT];
      monitor_mode_o <= mode;
      monitor_ms_o <= mon_ctrl_q[MC_MS_BIT];
      monitor_complex_o <= mon_ctrl_q[MC_CPLX_BIT];
    end
  end

  // ==========================================================
  // Serial result port
  sp_if spi();

  always_comb begin
    case (mode)
      MON_RMS: mode_out_en = result_serial_port_q[SP_RMS_BIT];
      MON_PEAK: mode_out_en = result_serial_port_q[SP_PEAK_BIT];
      default: mode_out_en = result_serial_port_q[SP_THR_BIT];
    endcase
  end
  assign spi.start = period_end_o && mode_out_en;
  assign spi.en = result_serial_port_q[SP_EN_BIT];
  assign spi.sleep = result_serial_port_q[SP_SLEEP_BIT];
  assign spi.div_code = result_serial_port_q[3:2];
  assign spi.nbits = (mode == MON_RMS) ? BITS_RMS : BITS_SHORT;
  assign spi.word_a = res_a_q;
  assign spi.word_b = res_b_q;
  assign result_serial_port_clk_o = spi.bit_clk;
  assign result_serial_port_data_o = spi.bit_data;
  assign result_serial_port_frame_o = spi.frame;

  result_port u_port (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .sp (spi.port)
  );

endmodule : adc_monitor_sync_detect_regs

// [verif/regs_checker_asserts.sv]
`timescale 1ns/100ps
// ====
// Register bank checker
module regs_checker
  import mon_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Watched ports
  input wire logic [12:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic sync_i,
  input wire logic monitor_sync_o,
  input wire logic divider_sync_o,
  input wire logic fast_flag_oe_o,
  input wire logic [13:0] dc_applied_a_o
);
  logic [4:0] c_q;
  // Written bits: 2 master, 1 monitor, 0 once, 3 flag enable, 4 freeze
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c_q <= '0;
    end else if (reg_wr_i && reg_addr_i == ADDR_SYNC) begin
      c_q[2:0] <= {reg_wdata_i[0], reg_wdata_i[7], reg_wdata_i[2]};
    end else if (reg_wr_i && reg_addr_i == ADDR_FD_CTRL) begin
      c_q[3] <= reg_wdata_i[0];
    end else if (reg_wr_i && reg_addr_i == ADDR_DC_CTRL) begin
      c_q[4] <= reg_wdata_i[6];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_MON_SYNC: assert property (1 |=> monitor_sync_o ==
    ($past(sync_i) && $past(c_q[2]) && $past(c_q[1])))
    else $error("monitor sync wrong");
  AST_DIV_SYNC: assert property (divider_sync_o |-> $past(sync_i) && $past(c_q[2]))
    else $error("divider sync without cause");
  AST_MASTER_OFF: assert property (!c_q[2] |=> !monitor_sync_o && !divider_sync_o)
    else $error("sync passed with master off");
  AST_ONCE: assert property (divider_sync_o && c_q[0] && !$past(reg_wr_i)
    |=> !divider_sync_o) else $error("second divider sync");
  AST_FLAG_OFF: assert property (!c_q[3] |=> !fast_flag_oe_o)
    else $error("flag pins driven while off");
  AST_FREEZE: assert property (c_q[4] |=> $stable(dc_applied_a_o))
    else $error("dc value moved while frozen");
  AST_OPEN_HI: assert property (reg_rd_i && reg_addr_i == ADDR_FHI_HI
    |=> reg_rdata_o[7:5] == 3'h0) else $error("open bits read nonzero");
  AST_RES_TOP: assert property (reg_rd_i && reg_addr_i == ADDR_RES_A2
    |=> reg_rdata_o[7:4] == 4'h0) else $error("result top byte wrong");
  cover property (divider_sync_o && c_q[0]);
  cover property (monitor_sync_o);
  cover property (c_q[4] && reg_wr_i);
endmodule : regs_checker

bind adc_monitor_sync_detect_regs regs_checker regs_checker_inst (.sys_clk_i, .reset_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sync_i, .monitor_sync_o,
  .divider_sync_o, .fast_flag_oe_o, .dc_applied_a_o);

// [verif/ctrl_host.sv]
`timescale 1ns/100ps
// ====
// Host on the register access port
module ctrl_host (
  // Clock
  input wire logic sys_clk_i,
  // Strobes
  output logic [12:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  // Read return
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
  // One write strobe cycle off the falling edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'h1};
    @(negedge sys_clk_i);
    {reg_wdata_o, reg_wr_o} = {~d, 1'h0};
  endtask : wr
  // One read strobe; data comes back a cycle later
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk_i);
    {reg_addr_o, reg_rd_o} = {a, 1'h1};
    @(negedge sys_clk_i);
    reg_rd_o = 1'h0;
    {d, v} = {reg_rdata_i, reg_rvalid_i};
  endtask : rd
endmodule : ctrl_host

// [verif/tb_adc_monitor_sync_detect_regs.sv]
`timescale 1ns/100ps
module tb_adc_monitor_sync_detect_regs
  import mon_pkg::*;
;
  logic sys_clk_i = 1'h0;
  logic reset_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, sync_i, monitor_sync_o, divider_sync_o;
  logic interleave_i, chan_a_off_i, chan_b_off_i, fast_flag_oe_o, period_end_o, ok, sclk, cx, ms;
  logic [12:0] reg_addr_i, mag_a_i, mag_b_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, rd;
  logic [1:0] fine_high_flag_o, fine_low_flag_o, gain_raise_o, monitor_mode_o;
  logic [3:0] fast_flag_o;
  logic [13:0] dc_calc_a_i, dc_applied_a_o;
  logic [19:0] result_a_i, result_b_i, n;
  logic [7:0] res_v[6] = '{8'hDE, 8'hBC, 8'h0A, 8'h45, 8'h23, 8'h01};
  int n_errors = 0;
  int checks_done = 0;
  // ====
  // Clock, design and host
  always #50 sys_clk_i = ~sys_clk_i;
  adc_monitor_sync_detect_regs adc_monitor_sync_detect_regs_inst (.sys_clk_i, .reset_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .sync_i,
    .monitor_sync_o, .divider_sync_o, .mag_a_i, .mag_b_i, .interleave_i, .chan_a_off_i,
    .chan_b_off_i, .fast_flag_o, .fast_flag_oe_o, .fine_high_flag_o, .fine_low_flag_o,
    .gain_raise_o, .dc_calc_a_i, .dc_calc_b_i(14'h0000), .dc_applied_a_o,
    .dc_applied_b_o(), .dc_ctrl_o(), .result_a_i, .result_b_i, .monitor_en_o(),
    .monitor_mode_o, .monitor_ms_o(ms), .monitor_complex_o(cx), .period_end_o,
    .result_serial_port_clk_o(sclk), .result_serial_port_data_o(), .result_serial_port_frame_o());
  ctrl_host ctrl_host_inst (.sys_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));
  task automatic cy(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask : cy
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    ctrl_host_inst.wr(a, d);
  endtask : wr
  task automatic rc(input logic [12:0] a, input logic [7:0] exp);
    ctrl_host_inst.rd(a, rd, ok);
    chk({11'h0, ok, rd}, {12'h001, exp});
  endtask : rc
  // Sync pulse of k cycles; counts passed monitor and divider cycles
  task automatic syn(input logic [7:0] s, input int k, input logic [7:0] exp);
    logic [3:0] nm, nd;
    wr(ADDR_SYNC, s);
    {nm, nd, sync_i} = 9'h001;
    for (int i = 0; i < k + 2; i++) begin
      cy(1);
      if (i == k - 1) sync_i = 1'h0;
      nm += {3'h0, monitor_sync_o};
      nd += {3'h0, divider_sync_o};
    end
    chk({12'h0, nm, nd}, {12'h0, exp});
  endtask : syn
  // Cycles up to the next period end pulse
  task automatic wait_pe(output logic [19:0] c);
    c = '0;
    do begin
      cy(1);
      c++;
    end while (!period_end_o && c < 20'h00400);
  endtask : wait_pe
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Watchdog at about twenty-five times the sequence length
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
  // Main sequence
  initial begin
    {reset_n_i, sync_i, interleave_i, chan_a_off_i, chan_b_off_i, mag_a_i, mag_b_i} = '0;
    {dc_calc_a_i, result_a_i, result_b_i} = {14'h0000, 20'hABCDE, 20'h12345};
    cy(6);
    reset_n_i = 1'h1;
    rc(ADDR_RESULT_SERIAL_PORT, 8'h04);
    rc(ADDR_PER_B0, 8'h80);
    wr(ADDR_FHI_HI, 8'hFF);
    rc(ADDR_FHI_HI, 8'h1F);
    wr(ADDR_RES_A0, 8'hFF);
    rc(ADDR_RES_A0, 8'h00);
    rc(13'h0150, 8'h00);
    n[0] = sclk;
    cy(1);
    chk({19'h0, n[0] ^ sclk}, 20'h00001);
    wr(ADDR_RESULT_SERIAL_PORT, 8'h06);
    cy(2);
    n[1] = sclk;
    cy(1);
    chk({18'h0, n[1], sclk}, 20'h00000);
    syn(8'h81, 3, 8'h30);
    syn(8'h82, 2, 8'h00);
    syn(8'h83, 2, 8'h22);
    syn(8'h07, 3, 8'h01);
    rc(ADDR_SYNC, 8'h05);
    syn(8'h05, 2, 8'h00);
    wr(ADDR_FHI_HI, 8'h01);
    wr(ADDR_FLO_LO, 8'h10);
    wr(ADDR_DWELL_LO, 8'h03);
    wr(ADDR_FD_CTRL, 8'h01);
    mag_a_i = 13'h0200;
    cy(8);
    n = {9'h0, fine_high_flag_o, fine_low_flag_o, gain_raise_o, fast_flag_oe_o, fast_flag_o};
    chk(n, {9'h0, 2'h1, 2'h2, 2'h2, 1'h1, 4'h3});
    mag_a_i = 13'h0005;
    cy(3);
    chk({16'h0, fine_low_flag_o, gain_raise_o}, 20'h0000E);
    cy(5);
    chk({18'h0, gain_raise_o}, 20'h00003);
    wr(ADDR_FD_CTRL, 8'h09);
    cy(2);
    chk({16'h0, fast_flag_o}, 20'h0000F);
    wr(ADDR_FD_CTRL, 8'h01);
    {mag_a_i, interleave_i, chan_b_off_i} = {13'h0200, 2'h3};
    cy(6);
    chk({15'h0, fast_flag_oe_o, fast_flag_o}, 20'h0001F);
    chan_a_off_i = 1'h1;
    cy(2);
    chk({19'h0, fast_flag_oe_o}, 20'h00000);
    {interleave_i, chan_a_off_i, chan_b_off_i, dc_calc_a_i} = {3'h0, 14'h0AAA};
    wr(ADDR_FD_CTRL, 8'h00);
    cy(3);
    chk({15'h0, fast_flag_oe_o, fast_flag_o}, 20'h00000);
    wr(ADDR_DC_CTRL, 8'h40);
    dc_calc_a_i = 14'h1555;
    cy(4);
    chk({6'h0, dc_applied_a_o}, 20'h00AAA);
    wr(ADDR_DC_CTRL, 8'h00);
    cy(4);
    chk({6'h0, dc_applied_a_o}, 20'h01555);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MON_CTRL, 8'h88 + 8'(2 * m));
      cy(2);
      chk({16'h0, cx, ms, monitor_mode_o}, (m > 1) ? 20'h0000E : 20'(12 + m));
    end
    wr(ADDR_MON_CTRL, 8'h01);
    wr(ADDR_PER_B0, 8'h10);
    wait_pe(n);
    wait_pe(n);
    chk(n, 20'h00080);
    foreach (res_v[i]) rc(ADDR_RES_A0 + 13'(i), res_v[i]);
    stop_test();
  end
endmodule : tb_adc_monitor_sync_detect_regs
